/* include/abh_regs.vh */
// Register offsets, field positions and opcode codes for the BCD/inc/dec/halt ALU slice
// Assumes a single AHB-Lite slave with 32-bit words at aligned byte addresses
`ifndef ABH_REGS_VH
`define ABH_REGS_VH

// Register byte offsets
`define ABH_OFF_CMD      4'h0
`define ABH_OFF_ACC      4'h4
`define ABH_OFF_STATUS   4'h8
`define ABH_OFF_RESULT   4'hC

// Status/flag bit positions
`define ABH_ZF_BIT       0
`define ABH_CF_BIT       1
`define ABH_ACF_BIT      2
`define ABH_PDF_BIT      3
`define ABH_TOF_BIT      4
`define ABH_BUSY_BIT     5

// Command register fields
`define ABH_CMD_OP_LSB   0
`define ABH_CMD_OP_MSB   2
`define ABH_CMD_ADR_LSB  8
`define ABH_CMD_ADR_MSB  15
`define ABH_CMD_WAKE_BIT 31

// Status write: preload data field for the addressed memory byte
`define ABH_LOAD_LSB     8
`define ABH_LOAD_MSB     15

// Operation codes
`define ABH_OP_NOP       3'h0
`define ABH_OP_DAA       3'h1
`define ABH_OP_DEC       3'h2
`define ABH_OP_DECREMENT_TO_ACC_OP      3'h3
`define ABH_OP_INC       3'h4
`define ABH_OP_INCREMENT_TO_ACC_OP      3'h5
`define ABH_OP_COMPLEMENT_TO_ACC_OP      3'h6
`define ABH_OP_HALT      3'h7

// Correction constants for decimal adjust, then accumulator and flag reset values
`define ABH_NIB_MAX      4'h9
`define ABH_NIB_FIX      4'h6
`define ABH_ACC_RST      8'h00
`define ABH_FLAG_RST     5'h00

`endif

/* hw/abh_alu.v */
// AHB-Lite slave ALU slice: decimal adjust, memory inc/dec, complement, halt
// Assumes one AHB-Lite master, word accesses only; data memory is held locally
//
// Local design decisions: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`include "abh_regs.vh"

module abh_alu #(
   parameter MEM_AW = 8                 // Data memory address width
)(
   input  wire        hclk,             // System clock, 40 MHz
   input  wire        hresetn,          // Async reset, active low
   input  wire        hsel,             // Slave select
   input  wire [31:0] haddr,            // Byte address
   input  wire [1:0]  htrans,           // Transfer type
   input  wire        hwrite,           // Write strobe
   input  wire [2:0]  hsize,            // Transfer size
   input  wire [31:0] hwdata,           // Write data
   input  wire        hready,           // Bus ready in
   output reg  [31:0] hrdata,           // Read data
   output wire        hreadyout,        // Always ready
   output wire        hresp,            // Always OKAY
   output wire        clk_gate_en,      // Core clock enable, low in power-down
   output reg         wdt_clear         // One-cycle watchdog and prescaler clear
);

   localparam DEPTH = 1 << MEM_AW;

   // Local data memory, retained across power-down
   reg [7:0]        mem_r [0:DEPTH-1];

   // Architectural state
   reg [7:0]        acc_r;
   reg              zf_r;
   reg              cf_r;
   reg              acf_r;
   reg              pdf_r;
   reg              tof_r;
   reg [7:0]        result_r;

   // Bus address phase capture
   reg              wr_pend_r;
   reg              rd_pend_r;
   reg [3:0]        addr_r;

   // Execution pipeline: one command issued, executed next cycle
   reg              exec_r;
   reg [2:0]        op_r;
   reg [MEM_AW-1:0] madr_r;

   wire             ph_valid;
   wire [7:0]       mbyte;
   wire [7:0]       inc_v;
   wire [7:0]       dec_v;
   wire [7:0]       cpl_v;
   wire             lo_fix;
   wire             hi_fix;
   wire             hi_chain;
   wire [3:0]       lo_adj;
   wire [3:0]       hi_adj;
   wire [7:0]       daa_add;
   wire [8:0]       daa_sum;
   wire             cmd_wr;
   wire             flag_wr;
   wire             acc_wr;
   wire             mem_load;

   // Next values of the architectural state
   reg  [7:0]       acc_nxt;
   reg              zf_nxt;
   reg              cf_nxt;
   reg              acf_nxt;
   reg              pdf_nxt;
   reg              tof_nxt;
   reg  [7:0]       result_nxt;
   reg              wdt_clear_nxt;

   // Data memory write port
   reg              mem_we;
   reg  [7:0]       mem_wd;

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // Clock to the rest of the core stops while power-down is set
   assign clk_gate_en = ~pdf_r;

   assign ph_valid = hsel & hready & htrans[1];
   assign cmd_wr   = wr_pend_r & (addr_r == `ABH_OFF_CMD);
   assign flag_wr  = wr_pend_r & (addr_r == `ABH_OFF_STATUS);
   assign acc_wr   = wr_pend_r & (addr_r == `ABH_OFF_ACC);
   assign mem_load = flag_wr & hwdata[`ABH_BUSY_BIT];

   // Address phase capture
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         addr_r    <= 4'h0;
      end
      else
      begin
         wr_pend_r <= ph_valid & hwrite;
         rd_pend_r <= ph_valid & ~hwrite;
         if (ph_valid)
            addr_r <= haddr[3:0];
      end
   end

   // Operand fetch and arithmetic results
   assign mbyte = mem_r[madr_r];
   assign inc_v = mbyte + 8'h01;
   assign dec_v = mbyte - 8'h01;
   assign cpl_v = ~mbyte;

   // Low digit: out of range or aux carry forces the correction
   abh_nib_adj u_lo_adj (
      .nib       (acc_r[3:0]),          // Low digit
      .force_fix (acf_r),               // Aux carry
      .chain     (1'b0),                // Nothing below the low digit
      .fix       (lo_fix),
      .adj       (lo_adj)               // Six or zero
   );

   // A low-digit carry out turns a high digit of nine into an out-of-range one
   assign hi_chain = lo_fix & (acc_r[7:4] == `ABH_NIB_MAX) & (acc_r[3:0] > `ABH_NIB_MAX);

   // High digit: out of range, carry set, or pushed over by the low digit
   abh_nib_adj u_hi_adj (
      .nib       (acc_r[7:4]),          // High digit
      .force_fix (cf_r),                // Carry
      .chain     (hi_chain),            // Carry out of the low digit
      .fix       (hi_fix),
      .adj       (hi_adj)               // Six or zero
   );

   // Correction constant 00, 06, 60 or 66 hex added to the accumulator
   assign daa_add = {hi_adj, lo_adj};
   assign daa_sum = {1'b0, acc_r} + {1'b0, daa_add};

   // Command issue: ignored while a previous command executes
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         exec_r <= 1'b0;
         op_r   <= `ABH_OP_NOP;
         madr_r <= {MEM_AW{1'b0}};
      end
      else
      begin
         exec_r <= 1'b0;
         if (cmd_wr && !exec_r && !pdf_r)
         begin
            exec_r <= 1'b1;
            op_r   <= hwdata[`ABH_CMD_OP_MSB:`ABH_CMD_OP_LSB];
            madr_r <= hwdata[`ABH_CMD_ADR_LSB +: MEM_AW];
         end
      end
   end

   // Data memory write select: inc, dec and decimal adjust write back; a status write can preload
   always @*
   begin
      mem_we = 1'b0;
      mem_wd = mbyte;
      if (exec_r)
      begin
         case (op_r)
            `ABH_OP_DAA:
            begin
               mem_we = 1'b1;
               mem_wd = daa_sum[7:0];
            end
            `ABH_OP_DEC:
            begin
               mem_we = 1'b1;
               mem_wd = dec_v;
            end
            `ABH_OP_INC:
            begin
               mem_we = 1'b1;
               mem_wd = inc_v;
            end
            default:
            begin
               mem_we = 1'b0;                   // Results to the accumulator leave memory alone
               mem_wd = mbyte;
            end
         endcase
      end
      else if (mem_load)
      begin
         mem_we = 1'b1;                         // Memory preload through a status write
         mem_wd = hwdata[`ABH_LOAD_MSB:`ABH_LOAD_LSB];
      end
   end

   // Data memory, no reset: contents survive power-down
   always @(posedge hclk)
   begin
      if (mem_we)
         mem_r[madr_r] <= mem_wd;
   end

   // Next accumulator, flags and result; an executing command wins over a bus write
   always @*
   begin
      acc_nxt       = acc_r;
      zf_nxt        = zf_r;
      cf_nxt        = cf_r;
      acf_nxt       = acf_r;
      pdf_nxt       = pdf_r;
      tof_nxt       = tof_r;
      result_nxt    = result_r;
      wdt_clear_nxt = 1'b0;
      if (exec_r)
      begin
         case (op_r)
            `ABH_OP_DAA:
            begin
               cf_nxt     = cf_r | daa_sum[8] | hi_fix;
               result_nxt = daa_sum[7:0];
            end
            `ABH_OP_DEC:
            begin
               zf_nxt     = (dec_v == 8'h00);
               result_nxt = dec_v;
            end
            `ABH_OP_DECREMENT_TO_ACC_OP:
            begin
               acc_nxt    = dec_v;
               zf_nxt     = (dec_v == 8'h00);
               result_nxt = dec_v;
            end
            `ABH_OP_INC:
            begin
               zf_nxt     = (inc_v == 8'h00);
               result_nxt = inc_v;
            end
            `ABH_OP_INCREMENT_TO_ACC_OP:
            begin
               acc_nxt    = inc_v;
               zf_nxt     = (inc_v == 8'h00);
               result_nxt = inc_v;
            end
            `ABH_OP_COMPLEMENT_TO_ACC_OP:
            begin
               acc_nxt    = cpl_v;
               zf_nxt     = (cpl_v == 8'h00);
               result_nxt = cpl_v;
            end
            `ABH_OP_HALT:
            begin
               pdf_nxt       = 1'b1;
               tof_nxt       = 1'b0;
               wdt_clear_nxt = 1'b1;
            end
            default: ;
         endcase
      end
      else if (cmd_wr && hwdata[`ABH_CMD_WAKE_BIT])
         pdf_nxt = 1'b0;                                       // Wake from power-down
      else if (acc_wr && !pdf_r)
         acc_nxt = hwdata[7:0];                                // Register writes refused in power-down
      else if (flag_wr && !pdf_r)
      begin
         zf_nxt  = hwdata[`ABH_ZF_BIT];
         cf_nxt  = hwdata[`ABH_CF_BIT];
         acf_nxt = hwdata[`ABH_ACF_BIT];
         tof_nxt = hwdata[`ABH_TOF_BIT];
      end
   end

   // Accumulator, flags and result registers
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         acc_r     <= `ABH_ACC_RST;
         zf_r      <= 1'b0;
         cf_r      <= 1'b0;
         acf_r     <= 1'b0;
         pdf_r     <= 1'b0;
         tof_r     <= 1'b0;
         result_r  <= `ABH_ACC_RST;
         wdt_clear <= 1'b0;
      end
      else
      begin
         acc_r     <= acc_nxt;
         zf_r      <= zf_nxt;
         cf_r      <= cf_nxt;
         acf_r     <= acf_nxt;
         pdf_r     <= pdf_nxt;
         tof_r     <= tof_nxt;
         result_r  <= result_nxt;
         wdt_clear <= wdt_clear_nxt;
      end
   end

   // Read data
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= 32'h00000000;
      else if (ph_valid && !hwrite)
      begin
         case (haddr[3:0])
            `ABH_OFF_ACC:    hrdata <= {24'h000000, acc_r};
            `ABH_OFF_STATUS: hrdata <= {26'h0000000, exec_r, tof_r, pdf_r, acf_r, cf_r, zf_r};
            `ABH_OFF_RESULT: hrdata <= {24'h000000, result_r};
            default:         hrdata <= 32'h00000000;
         endcase
      end
   end

endmodule // abh_alu

// Adds six to one BCD digit when it is out of range or a flag forces it
module abh_nib_adj #(
   parameter [3:0] LIMIT = `ABH_NIB_MAX, // Largest digit left alone
   parameter [3:0] STEP  = `ABH_NIB_FIX  // Amount added on correction
)(
   input  wire [3:0] nib,               // Digit before correction
   input  wire       force_fix,         // Flag that forces the correction
   input  wire       chain,             // Extra cause from the digit below
   output wire       fix,               // Correction applied
   output wire [3:0] adj                // Amount added to the digit
);

   // Correction decision and amount
   assign fix = (nib > LIMIT) | force_fix | chain;
   assign adj = fix ? STEP : 4'h0;

endmodule // abh_nib_adj

/* test/abh_alu_asserts.sv */
// Checker for the ALU slice bus answers and power-down outputs
// Assumes the port names of abh_alu; bound below
`timescale 1ns/1ps
module abh_alu_asserts (
   input wire        hclk,        // Clock
   input wire        hresetn,     // Reset, low
   input wire        hsel,        // Select
   input wire [31:0] haddr,       // Address
   input wire [1:0]  htrans,      // Transfer type
   input wire        hwrite,      // Write
   input wire [31:0] hwdata,      // Write data
   input wire        hready,      // Ready in
   input wire [31:0] hrdata,      // Read data
   input wire        hreadyout,   // Ready out
   input wire        hresp,       // Response
   input wire        clk_gate_en, // Clock enable
   input wire        wdt_clear    // Watchdog clear
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Address phase decodes
   wire rd_ap = hsel && hready && htrans[1] && !hwrite;
   wire cw_ap = hsel && hready && htrans[1] && hwrite && haddr[3:0] == 4'h0;
   chk_ready_high: assert property (hreadyout) else $error("wait state seen");
   chk_resp_okay: assert property (!hresp) else $error("error response seen");
   chk_halt_acts: assert property (cw_ap && clk_gate_en ##1 hwdata[2:0] == 3'h7 |->
      ##[1:3] (wdt_clear && !clk_gate_en)) else $error("halt not taken");
   chk_wdt_pulse: assert property (wdt_clear |=> !wdt_clear) else $error("clear too long");
   chk_gate_cause: assert property ($fell(clk_gate_en) |-> wdt_clear) else $error("gate without halt");
   chk_wake_cause: assert property ($rose(clk_gate_en) |-> $past(hwdata[31]) || $past(hwdata[31], 2)
      || $past(hwdata[31], 3)) else $error("wake without request");
   chk_pd_hold: assert property ((!clk_gate_en && !hwdata[31]) [*3] |=> !clk_gate_en)
      else $error("power-down left");
   chk_rdata_hold: assert property (!rd_ap |=> $stable(hrdata)) else $error("read data moved");
endmodule // abh_alu_asserts

bind abh_alu abh_alu_asserts u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .clk_gate_en(clk_gate_en), .wdt_clear(wdt_clear));

/* test/testbench.sv */
// Self-checking bench for the ALU slice over AHB-Lite
// Assumes abh_alu with its checker bound by the checker file
`timescale 1ns/1ps
`include "abh_regs.vh"
`define CK(a, b) begin n_compared++; if ((a) !== (b)) begin n_fail++; $display("BAD %0t %h %h", $time, a, b); end end
module testbench;
   logic        hclk, hresetn, hsel, hwrite;
   logic [31:0] haddr, hwdata, rv;
   logic [1:0]  htrans;
   wire  [31:0] hrdata;
   wire         hreadyout, hresp, clk_gate_en, wdt_clear;
   int          n_fail, n_compared, cyc, n_wdt;
   abh_alu DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .clk_gate_en(clk_gate_en), .wdt_clear(wdt_clear));
   // Clock at 40 MHz
   initial
   begin
      hclk = 0;
      forever #12.5 hclk = ~hclk;
   end
   // Hang guard and count of watchdog clear pulses
   always @(posedge hclk)
   begin
      cyc++;
      if (wdt_clear === 1'b1)
         n_wdt++;
      if (cyc == 3000)
      begin
         n_fail++;
         complete_run;
      end
   end
   task complete_run;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // One single word transfer; read data lands in rv
   task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rv = hrdata;
   endtask
   task rd(input logic [31:0] a);
      xfer(1'b0, a, 32'h0);
   endtask
   // Command word, then the cycles it takes to execute
   task cmd(input logic [2:0] op, input logic [7:0] m, input logic wk);
      xfer(1'b1, `ABH_OFF_CMD, {wk, 15'h0, m, 5'h0, op});
      repeat (3) @(posedge hclk);
   endtask
   task t_reset;
      rd(`ABH_OFF_ACC);
      `CK(rv, 32'h0)
      rd(`ABH_OFF_STATUS);
      `CK(rv, 32'h0)
      rd(32'h10);
      `CK(rv, 32'h0)
   endtask
   // Byte FF with carry set, then a chain of memory operations
   task t_incdec;
      cmd(`ABH_OP_NOP, 8'h10, 1'b0);
      xfer(1'b1, `ABH_OFF_STATUS, 32'hFF22);
      cmd(`ABH_OP_INC, 8'h10, 1'b0);
      rd(`ABH_OFF_RESULT);
      `CK(rv[7:0], 8'h00)
      rd(`ABH_OFF_STATUS);
      `CK(rv[1:0], 2'h3)
      cmd(`ABH_OP_DECREMENT_TO_ACC_OP, 8'h10, 1'b0);
      rd(`ABH_OFF_ACC);
      `CK(rv[7:0], 8'hFF)
      rd(`ABH_OFF_STATUS);
      `CK(rv[1:0], 2'h2)
      cmd(`ABH_OP_DEC, 8'h10, 1'b0);
      rd(`ABH_OFF_RESULT);
      `CK(rv[7:0], 8'hFF)
      cmd(`ABH_OP_COMPLEMENT_TO_ACC_OP, 8'h10, 1'b0);
      rd(`ABH_OFF_ACC);
      `CK(rv[7:0], 8'h00)
      xfer(1'b1, `ABH_OFF_ACC, 32'h55);
      cmd(`ABH_OP_INCREMENT_TO_ACC_OP, 8'h10, 1'b0);
      rd(`ABH_OFF_ACC);
      `CK(rv[7:0], 8'h00)
      rd(`ABH_OFF_STATUS);
      `CK(rv[1:0], 2'h3)
      cmd(`ABH_OP_DEC, 8'h10, 1'b0);
      rd(`ABH_OFF_RESULT);
      `CK(rv[7:0], 8'hFE)
   endtask
   // Decimal adjust of one value with given aux carry and carry
   task daa1(input logic [7:0] a, input logic [1:0] fl, input logic [7:0] e, input logic co);
      xfer(1'b1, `ABH_OFF_ACC, {24'h0, a});
      xfer(1'b1, `ABH_OFF_STATUS, {29'h0, fl, 1'b1});
      cmd(`ABH_OP_DAA, 8'h20, 1'b0);
      rd(`ABH_OFF_RESULT);
      `CK(rv[7:0], e)
      rd(`ABH_OFF_STATUS);
      `CK(rv[1:0], {co, 1'b1})
      rd(`ABH_OFF_ACC);
      `CK(rv[7:0], a)
      cmd(`ABH_OP_INCREMENT_TO_ACC_OP, 8'h20, 1'b0);
      rd(`ABH_OFF_ACC);
      `CK(rv[7:0], e + 8'h01)
   endtask
   task t_daa;
      daa1(8'h15, 2'b00, 8'h15, 1'b0);
      daa1(8'h1A, 2'b00, 8'h20, 1'b0);
      daa1(8'h12, 2'b10, 8'h18, 1'b0);
      daa1(8'hA3, 2'b00, 8'h03, 1'b1);
      daa1(8'h23, 2'b01, 8'h83, 1'b1);
      daa1(8'h9A, 2'b00, 8'h00, 1'b1);
   endtask
   // Halt with time-out flag set, refused write, then wake
   task t_halt;
      xfer(1'b1, `ABH_OFF_ACC, 32'h5A);
      xfer(1'b1, `ABH_OFF_STATUS, 32'h10);
      cmd(`ABH_OP_HALT, 8'h00, 1'b0);
      `CK(clk_gate_en, 1'b0)
      `CK(n_wdt, 1)
      rd(`ABH_OFF_STATUS);
      `CK(rv[4:3], 2'b01)
      xfer(1'b1, `ABH_OFF_ACC, 32'h0);
      rd(`ABH_OFF_ACC);
      `CK(rv[7:0], 8'h5A)
      cmd(`ABH_OP_NOP, 8'h00, 1'b1);
      `CK(clk_gate_en, 1'b1)
   endtask
   // Reset, then the scenarios
   initial
   begin
      {hresetn, hsel, hwrite, haddr, hwdata, htrans} = '0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset;
      t_incdec;
      t_daa;
      t_halt;
      complete_run;
   end
endmodule // testbench
